/* File: evpu_top.sv */
`timescale 1ns/1ps

// How it works
// R1 - Reset ranks first, starts on pin release
// R2 - Watchdog overflow resets, then reset vector
// R3 - Trap operand picks vectors 8 to 11
// R4 - Traps are never held by mask
// R5 - Mask bit holds all but traps, unmaskable, break
// R6 - Interrupts start only at instruction boundary
// R7 - Lowest pending vector number wins
// R8 - Vector address is twice the number
// R9 - Fixed vector numbers for core sources
// R10 - Shared peripheral vectors 21 to 24
// R11 - Vectors 1 to 6, 20 never produced
// R12 - Polarity bit 7 unmaskable, 3..0 requests
// R13 - Polarity bits 6..4 read one, ignore writes
// R14 - Polarity resets to falling edges
// R15 - Synced pins, selected edge latches pending
module evpu_top (
  input wire logic clk_in,             // System clock
  input wire logic sys_rst_in,         // Sync reset, high
  input wire logic clk_en_in,          // Freezes state when low
  input wire logic psel_in,            // APB select
  input wire logic penable_in,         // APB enable
  input wire logic pwrite_in,          // APB direction
  input wire logic [11:0] paddr_in,    // APB byte address
  input wire logic [31:0] pwdata_in,   // APB write data
  output logic pready_out,             // APB ready
  output logic [31:0] prdata_out,      // APB read data
  output logic pslverr_out,            // APB error
  input wire logic power_on_init_pin_n_in, // Reset pin, low
  input wire logic wdt_ovf_in,         // Watchdog overflow
  input wire logic unmask_pin_in,      // Unmaskable pin
  input wire logic [3:0] ext_req_pin_in, // Request pins 3..0
  input wire logic trap_in,            // Trap executed pulse
  input wire logic [1:0] trap_num_in,  // Trap operand
  input wire logic cond_mask_in,       // Global mask bit
  input wire logic insn_end_in,        // Instruction boundary
  input wire logic vec_ack_in,         // Core took vector
  input wire evpu_pkg::evpu_periph_s periph_in, // Level requests
  output logic core_reset_out,         // Core held in reset
  output logic vec_valid_out,          // Vector offered
  output logic [4:0] vec_num_out,      // Vector number
  output logic [15:0] vec_addr_out,    // Vector table address
  output logic irq_out                 // Unmasked event
);

  // ****************************************************
  // Functions
  // ****************************************************

  // Selected edge per pin, polarity 1 means rising
  function automatic logic [4:0] edge_hit(
    input logic [4:0] prev,
    input logic [4:0] cur,
    input logic [4:0] pol);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 5; i++) begin
      r[i] = pol[i] ? (!prev[i] && cur[i])
                    : (prev[i] && !cur[i]);
    end
    return r;
  endfunction

  // Lowest set bit number is the highest priority
  // Scans downward, so the lowest request is the one kept
  function automatic logic [5:0] pick(input logic [25:0] req);
    logic [5:0] r;
    r = 6'h00;
    for (int i = evpu_pkg::NUM_VEC - 1; i >= 0; i--) begin
      if (req[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // Register read mux; unmapped addresses read zero
  // Status and mask share one bit layout
  function automatic logic [31:0] rd_val(
    input logic [11:0] a,
    input evpu_pkg::evpu_state_s st);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      evpu_pkg::ADDR_EDGE_POL:
        r[7:0] = {st.pol[4], evpu_pkg::POL_RSVD_VAL,
                  st.pol[3:0]}; // [R12] [R13]
      evpu_pkg::ADDR_STATUS: r[evpu_pkg::EV_W-1:0] = st.sts;
      evpu_pkg::ADDR_MASK: r[evpu_pkg::EV_W-1:0] = st.msk;
      evpu_pkg::ADDR_VECTOR:
        r[7:0] = {1'b0, st.phase, st.vec_num};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ****************************************************
  // State and decode
  // ****************************************************
  localparam int EV_W_L = evpu_pkg::EV_W;

  evpu_pkg::evpu_state_s s_r;
  evpu_pkg::evpu_state_s s_nxt;
  logic [4:0] pol_by_pin;
  logic [4:0] edges;
  logic pin_low;
  logic apb_setup;
  logic apb_wr;
  logic wr_pol;
  logic wr_sts;
  logic wr_msk;
  logic mapped;
  logic [25:0] req;
  logic [25:0] req_ok;
  logic [5:0] win;
  logic taken;
  logic rst_leave;
  logic [EV_W_L-1:0] ev_set;
  logic [EV_W_L-1:0] ev_clr;

  // Polarity bits put in sync chain order: unmaskable pin first,
  // then request pins 0 to 3
  assign pol_by_pin = {s_r.pol[3:0], s_r.pol[4]}; // [R12]

  // Edge detect on the second sync stage and its history;
  // bit 0 of the chain is the reset pin, so requests sit at 5:1
  assign edges = edge_hit(s_r.pin_prev, s_r.pin_s2[5:1],
                          pol_by_pin); // [R15]
  assign pin_low = !s_r.pin_s2[0];

  // APB phase decode and per-register write strobes
  assign apb_setup = psel_in && !penable_in;
  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign wr_pol = apb_wr && (paddr_in == evpu_pkg::ADDR_EDGE_POL);
  assign wr_sts = apb_wr && (paddr_in == evpu_pkg::ADDR_STATUS);
  assign wr_msk = apb_wr && (paddr_in == evpu_pkg::ADDR_MASK);
  assign mapped = (paddr_in == evpu_pkg::ADDR_EDGE_POL) ||
                  (paddr_in == evpu_pkg::ADDR_STATUS) ||
                  (paddr_in == evpu_pkg::ADDR_MASK) ||
                  (paddr_in == evpu_pkg::ADDR_VECTOR);

  // Request vector, reserved numbers stay zero
  // Shared vectors are the OR of their group; sources clear themselves
  always_comb begin
    req = 26'h0000000; // [R11]
    req[evpu_pkg::VEC_NMI] = s_r.nmi_pend; // [R9]
    req[evpu_pkg::VEC_TRAP0 + 5'(s_r.trap_num)] =
      s_r.trap_pend; // [R3]
    req[evpu_pkg::VEC_BRK] = periph_in.brk;
    req[evpu_pkg::VEC_SLEEP] = periph_in.sleep;
    req[evpu_pkg::VEC_IRQ0 +: 4] = s_r.irq_pend;
    req[evpu_pkg::VEC_WAKEUP] = periph_in.wakeup;
    req[evpu_pkg::VEC_TMA] = periph_in.tma;
    req[evpu_pkg::VEC_CAP] = |periph_in.cap; // [R10]
    req[evpu_pkg::VEC_CMP] = |periph_in.cmp;
    req[evpu_pkg::VEC_SER] = |periph_in.ser;
    req[evpu_pkg::VEC_I2C] = |periph_in.i2c;
    req[evpu_pkg::VEC_ADC] = periph_in.adc;
  end

  // Global mask leaves traps, unmaskable and break
  assign req_ok = cond_mask_in ? (req & evpu_pkg::MASK_IMMUNE)
                               : req; // [R4] [R5]
  assign win = pick(req_ok); // [R7]
  // Core has taken the vector now on offer
  assign taken = (s_r.phase == evpu_pkg::PH_PRESENT) && vec_ack_in;

  // Leaving reset hold: count spent, pin high, no new overflow
  assign rst_leave = (s_r.phase == evpu_pkg::PH_HOLD) &&
                     (s_r.hold_cnt == 8'h00) && !pin_low &&
                     !wdt_ovf_in; // [R1]

  // Event set and write-one clear
  always_comb begin
    ev_set = '0;
    ev_set[evpu_pkg::EV_TAKEN] = taken;
    ev_set[evpu_pkg::EV_RESET] = rst_leave;
    ev_set[evpu_pkg::EV_NMI] = edges[0];
    ev_set[evpu_pkg::EV_IRQ] = |edges[4:1];
    // Software clear by writing ones
    ev_clr = '0;
    if (wr_sts) begin
      ev_clr = pwdata_in[EV_W_L-1:0];
    end
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    s_nxt = s_r;
    // Two-stage pin sync, then history for edges
    s_nxt.pin_s1 = {ext_req_pin_in, unmask_pin_in,
                    power_on_init_pin_n_in};
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_prev = s_r.pin_s2[5:1];
    // Register writes
    if (wr_pol) begin
      s_nxt.pol = {pwdata_in[evpu_pkg::POL_NMI_BIT],
                   pwdata_in[3:0]}; // [R12] [R13]
    end
    if (wr_msk) begin
      s_nxt.msk = pwdata_in[EV_W_L-1:0];
    end
    // Read data captured in the setup cycle
    if (apb_setup && !pwrite_in) begin
      s_nxt.prdata = rd_val(paddr_in, s_r);
    end
    // Pending requests, set wins over service clear
    s_nxt.nmi_pend = (s_r.nmi_pend &&
      !(taken && s_r.vec_num == evpu_pkg::VEC_NMI)) ||
      edges[0]; // [R15]
    for (int i = 0; i < 4; i++) begin
      s_nxt.irq_pend[i] = (s_r.irq_pend[i] && !(taken &&
        s_r.vec_num == evpu_pkg::VEC_IRQ0 + 5'(i))) ||
        edges[i+1]; // [R15]
    end
    // Any trap vector taken clears the single trap pending;
    // a new trap in that same cycle wins over the clear
    if (taken && s_r.vec_num[4:2] == 3'h2) begin
      s_nxt.trap_pend = 1'b0;
    end
    if (trap_in) begin
      s_nxt.trap_pend = 1'b1; // [R3]
      s_nxt.trap_num = trap_num_in;
    end
    // Exception sequencing: the reset vector needs no boundary,
    // every other source waits for one
    case (s_r.phase)
      evpu_pkg::PH_HOLD: begin
        if (s_r.hold_cnt != 8'h00) begin
          s_nxt.hold_cnt = s_r.hold_cnt - 8'h01;
        end else if (!pin_low) begin
          s_nxt.phase = evpu_pkg::PH_PRESENT; // [R1] [R2]
          s_nxt.vec_num = evpu_pkg::VEC_RESET;
        end
      end
      evpu_pkg::PH_RUN: begin
        if (insn_end_in && win[5]) begin
          s_nxt.phase = evpu_pkg::PH_PRESENT; // [R6]
          s_nxt.vec_num = win[4:0];
        end
      end
      evpu_pkg::PH_PRESENT: begin
        if (vec_ack_in) begin
          s_nxt.phase = evpu_pkg::PH_RUN; // [R6]
        end
      end
      default: begin
        s_nxt.phase = evpu_pkg::PH_HOLD;
      end
    endcase
    // Pin or watchdog reset overrides everything; mask and status
    // survive it so software can see what happened before
    if (pin_low || wdt_ovf_in) begin
      s_nxt.phase = evpu_pkg::PH_HOLD; // [R1] [R2]
      s_nxt.pol = evpu_pkg::POL_RST; // [R14]
      s_nxt.nmi_pend = 1'b0;
      s_nxt.irq_pend = 4'h0;
      s_nxt.trap_pend = 1'b0;
    end
    if (wdt_ovf_in) begin
      s_nxt.hold_cnt = evpu_pkg::WDT_RST_CYC; // [R2]
    end
    s_nxt.sts = (s_r.sts & ~ev_clr) | ev_set;
  end

  // ****************************************************
  // State register
  // ****************************************************
  // Sync stages reset to the pins' idle high level, so that no
  // false falling edge appears in the first cycles after reset.
  // Clock enable low freezes every flop, sync stages included.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_r <= '{pin_s1: 6'h3f, pin_s2: 6'h3f,
               pin_prev: 5'h1f,
               pol: evpu_pkg::POL_RST, // [R14]
               nmi_pend: 1'b0, irq_pend: 4'h0,
               trap_pend: 1'b0, trap_num: 2'h0,
               phase: evpu_pkg::PH_HOLD, // [R1]
               hold_cnt: 8'h00, vec_num: 5'h00,
               sts: '0, msk: '0,
               prdata: 32'h0000_0000};
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // APB answers with no wait states; unmapped access flags error
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign prdata_out = s_r.prdata;
  // Vector link, all from registered state
  assign core_reset_out = (s_r.phase == evpu_pkg::PH_HOLD);
  assign vec_valid_out = (s_r.phase == evpu_pkg::PH_PRESENT);
  assign vec_num_out = s_r.vec_num;
  // Two-byte entries at twice the vector number
  assign vec_addr_out = {10'h000, s_r.vec_num, 1'b0}; // [R8]
  // Level interrupt while any unmasked status bit is set
  assign irq_out = |(s_r.sts & s_r.msk);

endmodule // evpu_top

/* File: evpu_pkg.sv */
package evpu_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDT_RST_NS = 100;
  // Least time, rounded up to whole cycles
  localparam logic [7:0] WDT_RST_CYC =
    8'((WDT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [11:0] ADDR_EDGE_POL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;
  localparam logic [11:0] ADDR_VECTOR = 12'h00c;
  localparam int POL_NMI_BIT = 7;
  localparam logic [2:0] POL_RSVD_VAL = 3'h7;
  localparam logic [4:0] POL_RST = 5'h00;
  localparam int EV_W = 4;
  localparam int EV_TAKEN = 0;
  localparam int EV_RESET = 1;
  localparam int EV_NMI = 2;
  localparam int EV_IRQ = 3;

  // ****************************************************
  // Vector numbers
  // ****************************************************
  localparam int NUM_VEC = 26;
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_NMI = 5'h07;
  localparam logic [4:0] VEC_TRAP0 = 5'h08;
  localparam logic [4:0] VEC_BRK = 5'h0c;
  localparam logic [4:0] VEC_SLEEP = 5'h0d;
  localparam logic [4:0] VEC_IRQ0 = 5'h0e;
  localparam logic [4:0] VEC_WAKEUP = 5'h12;
  localparam logic [4:0] VEC_TMA = 5'h13;
  localparam logic [4:0] VEC_CAP = 5'h15;
  localparam logic [4:0] VEC_CMP = 5'h16;
  localparam logic [4:0] VEC_SER = 5'h17;
  localparam logic [4:0] VEC_I2C = 5'h18;
  localparam logic [4:0] VEC_ADC = 5'h19;
  // Sources that ignore the global mask bit
  localparam logic [25:0] MASK_IMMUNE = 26'h0001f81;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {PH_HOLD, PH_RUN, PH_PRESENT} evpu_phase_e;

  typedef struct packed {
    logic brk;
    logic sleep;
    logic wakeup;
    logic tma;
    logic [4:0] cap;
    logic [2:0] cmp;
    logic [3:0] ser;
    logic [2:0] i2c;
    logic adc;
  } evpu_periph_s;

  typedef struct packed {
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [4:0] pin_prev;
    logic [4:0] pol;
    logic nmi_pend;
    logic [3:0] irq_pend;
    logic trap_pend;
    logic [1:0] trap_num;
    evpu_phase_e phase;
    logic [7:0] hold_cnt;
    logic [4:0] vec_num;
    logic [EV_W-1:0] sts;
    logic [EV_W-1:0] msk;
    logic [31:0] prdata;
  } evpu_state_s;

endpackage

/* File: evpu_properties.sv */
`timescale 1ns/1ps
// ****
// Vector link checks
// ****
module evpu_checker (
  input wire logic clk_in, // Clock
  input wire logic sys_rst_in, // Reset
  input wire logic power_on_init_pin_n_in, // Reset pin
  input wire logic wdt_ovf_in, // Watchdog
  input wire logic cond_mask_in, // Mask bit
  input wire logic insn_end_in, // Boundary
  input wire logic vec_ack_in, // Taken
  input wire logic core_reset_out, // Core held
  input wire logic vec_valid_out, // Offer
  input wire logic [4:0] vec_num_out, // Number
  input wire logic [15:0] vec_addr_out // Address
);
  // One clock domain, quiet in reset
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  a_addr_twice: assert property (vec_valid_out |->
    vec_addr_out == {10'h000, vec_num_out, 1'b0}) else $error("address");
  a_no_reserved: assert property (vec_valid_out |->
    !(vec_num_out inside {[5'h01:5'h06], 5'h14})) else $error("reserved");
  a_offer_holds: assert property (vec_valid_out && !vec_ack_in |=>
    vec_valid_out && $stable(vec_num_out)) else $error("offer dropped");
  a_ack_drops: assert property (vec_valid_out && vec_ack_in |=>
    !vec_valid_out) else $error("offer kept");
  a_at_boundary: assert property ($rose(vec_valid_out) &&
    !$past(core_reset_out) |-> $past(insn_end_in)) else $error("boundary");
  a_mask_immune: assert property ($rose(vec_valid_out) &&
    $past(cond_mask_in) && !$past(core_reset_out) |->
    evpu_pkg::MASK_IMMUNE[vec_num_out]) else $error("masked taken");
  a_reset_first: assert property ($rose(vec_valid_out) &&
    $past(core_reset_out) |-> vec_num_out == 5'h00) else $error("reset");
  a_wdt_hold: assert property (wdt_ovf_in |=>
    core_reset_out [*8]) else $error("watchdog");
  a_pin_hold: assert property (!power_on_init_pin_n_in [*5] |->
    core_reset_out) else $error("reset pin");
endmodule // evpu_checker

bind evpu_top evpu_checker u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .power_on_init_pin_n_in(power_on_init_pin_n_in), .wdt_ovf_in(wdt_ovf_in),
  .cond_mask_in(cond_mask_in), .insn_end_in(insn_end_in),
  .vec_ack_in(vec_ack_in), .core_reset_out(core_reset_out),
  .vec_valid_out(vec_valid_out), .vec_num_out(vec_num_out),
  .vec_addr_out(vec_addr_out));

/* File: evpu_core_model.sv */
`timescale 1ns/1ps
// ****
// Core side of the vector link
// ****
module evpu_core_model (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Reset, high
  input wire logic run_in, // Execute instructions
  input wire logic slow_in, // Answer slowly
  input wire logic vec_valid_in, // Vector offered
  output logic insn_end_out, // Instruction boundary
  output logic vec_ack_out // Vector taken
);
  logic [1:0] cnt_r;
  // Boundary every cycle or every fourth; one ack per offer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= 2'h0;
      insn_end_out <= 1'b0;
      vec_ack_out <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      insn_end_out <= run_in && (!slow_in || cnt_r == 2'h3);
      vec_ack_out <= vec_valid_in && !vec_ack_out && (!slow_in || cnt_r[0]);
    end
  end
endmodule // evpu_core_model

/* File: exception_vector_priority_unit_bench.sv */
`timescale 1ns/1ps
// ****
// Bench for the exception vector unit
// ****
module exception_vector_priority_unit_bench;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, pin_n = 1'b1, wdt = 1'b0, nmi_pin = 1'b1;
  logic trap = 1'b0, cmask = 1'b0, run = 1'b0, slow = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, seed = 32'h3480, prdata_out;
  logic [3:0] ext_pin = 4'hf;
  logic [1:0] tn = 2'h0;
  logic [19:0] pr = 20'h00000;
  logic pready_out, pslverr_out, insn_end, vec_ack, core_reset_out;
  logic vec_valid_out, irq_out;
  logic [4:0] vec_num_out, pol;
  logic [15:0] vec_addr_out;
  logic [25:0] pend;
  logic [33:0] exp_v, seen;
  logic [33:0] exp_q[$];
  int n_mismatch = 0, compares = 0;

  evpu_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .power_on_init_pin_n_in(pin_n), .wdt_ovf_in(wdt), .unmask_pin_in(nmi_pin),
    .ext_req_pin_in(ext_pin), .trap_in(trap), .trap_num_in(tn),
    .cond_mask_in(cmask), .insn_end_in(insn_end), .vec_ack_in(vec_ack),
    .periph_in(evpu_pkg::evpu_periph_s'(pr)), .core_reset_out(core_reset_out),
    .vec_valid_out(vec_valid_out), .vec_num_out(vec_num_out),
    .vec_addr_out(vec_addr_out), .irq_out(irq_out));
  evpu_core_model core (.clk_in(clk_in), .rst_in(sys_rst_in), .run_in(run),
    .slow_in(slow), .vec_valid_in(vec_valid_out), .insn_end_out(insn_end),
    .vec_ack_out(vec_ack));

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  // Helpers: random source, request groups, expected vector word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [19:0] grp(input logic [4:0] v);
    case (v)
      5'h0c: grp = 20'h80000;
      5'h0d: grp = 20'h40000;
      5'h12: grp = 20'h20000;
      5'h13: grp = 20'h10000;
      5'h15: grp = 20'h0f800;
      5'h16: grp = 20'h00700;
      5'h17: grp = 20'h000f0;
      5'h18: grp = 20'h0000e;
      5'h19: grp = 20'h00001;
      default: grp = 20'h00000;
    endcase
  endfunction
  function automatic logic [33:0] vexp(input int v);
    vexp = {2'b00, 10'h000, 5'(v), 1'b0, 11'h000, 5'(v)};
  endfunction

  // Verdict and end of run
  task automatic final_report;
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_empty;
    int i;
    for (i = 0; i < 500 && exp_q.size() > 0; i++) @(posedge clk_in);
    if (exp_q.size() > 0) begin
      n_mismatch++;
      final_report;
    end
  endtask
  // APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (pready_out !== 1'b1 && i < 64);
    if (pready_out !== 1'b1) begin
      n_mismatch++;
      final_report;
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic check(input string nm);
    exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
    compares++;
    if (seen !== exp_v) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp_v, seen);
    end
  endtask

  // Monitor: vector takes and read data against the oldest note
  always @(posedge clk_in) begin
    if (!sys_rst_in && vec_valid_out && vec_ack) begin
      seen = {2'b00, vec_addr_out, 11'h000, vec_num_out};
      check("vector");
      pr <= pr & ~grp(vec_num_out);
    end else if (psel_in && penable_in && !pwrite_in && pready_out) begin
      seen = {irq_out, pslverr_out, prdata_out};
      check("read");
    end
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    exp_q.push_back(vexp(0));
    sys_rst_in <= 1'b0;
    wait_empty;
    rd(evpu_pkg::ADDR_EDGE_POL, 34'h70);
    seed = lfsr(seed);
    pol = {seed[7], seed[3:0]};
    apb(1'b1, evpu_pkg::ADDR_EDGE_POL, seed);
    rd(evpu_pkg::ADDR_EDGE_POL, {26'h0, pol[4], 3'h7, pol[3:0]});
    rd(12'h010, {2'b01, 32'h0});
    rd(evpu_pkg::ADDR_STATUS, 34'h3);
    apb(1'b1, evpu_pkg::ADDR_STATUS, 32'hf);
    nmi_pin <= ~pol[4];
    ext_pin <= ~pol[3:0];
    repeat (6) @(posedge clk_in);
    nmi_pin <= pol[4];
    ext_pin <= pol[3:0];
    trap <= 1'b1;
    tn <= seed[9:8];
    pr <= seed[31:12];
    cmask <= 1'b1;
    slow <= seed[5];
    @(posedge clk_in);
    trap <= 1'b0;
    pend = 26'h003c080;
    pend[8 + tn] = 1'b1;
    for (int v = 12; v < 26; v++)
      if (|(pr & grp(5'(v)))) pend[v] = 1'b1;
    repeat (10) @(posedge clk_in);
    for (int m = 1; m >= 0; m--) begin
      for (int v = 0; v < 26; v++)
        if (pend[v] && evpu_pkg::MASK_IMMUNE[v] == m[0])
          exp_q.push_back(vexp(v));
      run <= 1'b1;
      cmask <= m[0];
      wait_empty;
      repeat (10) @(posedge clk_in);
    end
    rd(evpu_pkg::ADDR_STATUS, 34'hd);
    apb(1'b1, evpu_pkg::ADDR_MASK, 32'h4);
    rd(evpu_pkg::ADDR_STATUS, {2'b10, 32'hd});
    apb(1'b1, evpu_pkg::ADDR_STATUS, 32'h4);
    rd(evpu_pkg::ADDR_STATUS, 34'h9);
    apb(1'b1, evpu_pkg::ADDR_MASK, 32'h0);
    exp_q.push_back(vexp(0));
    wdt <= 1'b1;
    @(posedge clk_in);
    wdt <= 1'b0;
    wait_empty;
    rd(evpu_pkg::ADDR_EDGE_POL, 34'h70);
    exp_q.push_back(vexp(0));
    pin_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    pin_n <= 1'b1;
    wait_empty;
    rd(evpu_pkg::ADDR_VECTOR, 34'h20);
    final_report;
  end
endmodule // exception_vector_priority_unit_bench
